// >>> logic/router_pkg.sv
package router_pkg;
    localparam int ADDR_W = 44;
    localparam int UNIT_LSB = 26;
    localparam int BASE_W = 18;
    localparam int NODE_RANGES = 8;
    localparam int SWITCH_RANGES = 6;
    localparam int WAYS = 4;
    localparam int PORT_W = 3;
    localparam int FINE_WAY_LSB = 7;
    // range word layout
    localparam int F_BASE_LSB = 0;
    localparam int F_SIZE_LSB = 18;
    localparam int F_SIZE_W = 5;
    localparam int F_GRANULARITY_SELECT_BIT = 23;
    localparam int F_EN_BIT = 24;
    localparam int F_OWN_LSB = 25;
    // register offsets
    localparam logic [11:0] OFS_NODE_RANGE = 12'h000;
    localparam logic [11:0] OFS_SWITCH_RANGE = 12'h020;
    localparam logic [11:0] OFS_SWITCH_PORTS = 12'h040;
    localparam logic [11:0] OFS_ERR_STATUS = 12'h060;
    localparam logic [11:0] OFS_ERR_ADDR_LO = 12'h064;
    localparam logic [11:0] OFS_ERR_ADDR_HI = 12'h068;
    localparam logic [31:0] RANGE_RST = 32'h0000_0000;
    localparam int ERR_ILLEGAL_BIT = 0;
    // destination attribute
    localparam logic [3:0] ATTR_UNDECODED = 4'h0;
    localparam logic [3:0] ATTR_DRAM = 4'h3;
    localparam logic [3:0] ATTR_COMPAT = 4'h4;

    typedef enum logic [1:0] {
        SRC_PROC = 2'b00,
        SRC_HUB = 2'b01,
        SRC_HOME = 2'b10,
        SRC_SWITCH = 2'b11
    } src_t;

    typedef enum logic [2:0] {
        DEST_NONE = 3'b000,
        DEST_LOCAL = 3'b001,
        DEST_SCALE = 3'b010,
        DEST_COMPAT = 3'b011,
        DEST_PORT = 3'b100,
        DEST_DROP = 3'b101,
        DEST_ABORT = 3'b110,
        DEST_OTHER = 3'b111
    } dest_t;
endpackage : router_pkg

// >>> logic/range_match.sv
`timescale 1ns/1ps
module range_match
    import router_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] cfg,
    output logic hit,
    output logic [1:0] way,
    output logic [ADDR_W-1:0] offset
);
    logic [ADDR_W-1:0] span_mask;
    logic [ADDR_W-1:0] base_addr;
    logic [F_SIZE_W-1:0] size_n;

    always_comb
    begin
        size_n = cfg[F_SIZE_LSB +: F_SIZE_W];
        span_mask = ~({ADDR_W{1'b1}} << (UNIT_LSB + int'(size_n)));
        base_addr = {cfg[F_BASE_LSB +: BASE_W], {UNIT_LSB{1'b0}}};
        hit = cfg[F_EN_BIT] && ((addr & ~span_mask) == (base_addr & ~span_mask));
        // location depends on offset only, so a reflected copy lands on the same cells
        offset = addr & span_mask;
        if (cfg[F_GRANULARITY_SELECT_BIT])
            way = addr[FINE_WAY_LSB +: 2];
        else
            way = 2'(offset >> (UNIT_LSB - 2 + int'(size_n)));
    end
endmodule : range_match

// >>> logic/memory_interleave_router.sv
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module memory_interleave_router
    import router_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    input wire logic [1:0] req_src,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_coherent,
    input wire logic req_line_inval,
    input wire logic req_noncoh_space,
    input wire logic req_special,
    input wire logic [3:0] req_attr,
    output logic rsp_valid,
    output logic [2:0] rsp_dest,
    output logic [3:0] rsp_attr,
    output logic rsp_coherent,
    output logic [PORT_W-1:0] rsp_port,
    output logic [1:0] rsp_way,
    output logic [ADDR_W-1:0] rsp_offset,
    output logic illegal_addr
);
    // ------------------------------------------------------------
    // range registers and matchers
    // ------------------------------------------------------------
    logic [31:0] node_cfg_r [NODE_RANGES], node_cfg_nxt [NODE_RANGES];
    logic [31:0] sw_cfg_r [SWITCH_RANGES], sw_cfg_nxt [SWITCH_RANGES];
    logic [4*PORT_W-1:0] sw_port_r [SWITCH_RANGES], sw_port_nxt [SWITCH_RANGES];
    logic [NODE_RANGES-1:0] node_hit;
    logic [1:0] node_way [NODE_RANGES];
    logic [ADDR_W-1:0] node_off [NODE_RANGES];
    logic [SWITCH_RANGES-1:0] sw_hit;
    logic [1:0] sw_way [SWITCH_RANGES];
    logic [ADDR_W-1:0] sw_off [SWITCH_RANGES];

    genvar gi;
    generate
        for (gi = 0; gi < NODE_RANGES; gi++)
        begin : g_node
            range_match u_match (
                .addr(req_addr),
                .cfg(node_cfg_r[gi]),
                .hit(node_hit[gi]),
                .way(node_way[gi]),
                .offset(node_off[gi])
            );
        end
        for (gi = 0; gi < SWITCH_RANGES; gi++)
        begin : g_switch
            range_match u_match (
                .addr(req_addr),
                .cfg(sw_cfg_r[gi]),
                .hit(sw_hit[gi]),
                .way(sw_way[gi]),
                .offset(sw_off[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // priority pick
    // ------------------------------------------------------------
    logic node_found;
    logic node_owned;
    logic [1:0] node_sel_way;
    logic [ADDR_W-1:0] node_sel_off;
    logic sw_found;
    logic [PORT_W-1:0] sw_sel_port;
    logic [1:0] sw_sel_way;
    logic [ADDR_W-1:0] sw_sel_off;

    always_comb
    begin
        node_found = 1'b0;
        node_owned = 1'b0;
        node_sel_way = 2'b00;
        node_sel_off = '0;
        // walk downward so the lowest index overwrites the rest
        for (int i = NODE_RANGES - 1; i >= 0; i--)
        begin
            if (node_hit[i])
            begin
                node_found = 1'b1;
                node_sel_way = node_way[i];
                node_sel_off = node_off[i];
                node_owned = node_cfg_r[i][F_OWN_LSB + int'(node_way[i])];
            end
        end
        sw_found = 1'b0;
        sw_sel_way = 2'b00;
        sw_sel_off = '0;
        sw_sel_port = sw_port_r[0][PORT_W-1:0];
        for (int i = SWITCH_RANGES - 1; i >= 0; i--)
        begin
            if (sw_hit[i])
            begin
                sw_found = 1'b1;
                sw_sel_way = sw_way[i];
                sw_sel_off = sw_off[i];
                sw_sel_port = sw_port_r[i][int'(sw_way[i]) * PORT_W +: PORT_W];
            end
        end
    end

    // a node range counts as local only for the ways this node owns
    logic local_hit;
    logic [3:0] attr_in;
    assign local_hit = node_found && node_owned;
    // undefined encodings collapse to undecoded
    assign attr_in = (req_attr == ATTR_DRAM || req_attr == ATTR_COMPAT) ? req_attr
                     : ATTR_UNDECODED;

    // ------------------------------------------------------------
    // routing decision
    // ------------------------------------------------------------
    logic rsp_valid_r, rsp_valid_nxt;
    dest_t dest_r, dest_nxt;
    logic [3:0] attr_r, attr_nxt;
    logic coh_r, coh_nxt;
    logic [PORT_W-1:0] port_r, port_nxt;
    logic [1:0] way_r, way_nxt;
    logic [ADDR_W-1:0] off_r, off_nxt;
    logic miss_event;

    always_comb
    begin
        rsp_valid_nxt = req_valid;
        dest_nxt = DEST_NONE;
        attr_nxt = ATTR_UNDECODED;
        coh_nxt = 1'b0;
        port_nxt = '0;
        way_nxt = node_sel_way;
        off_nxt = node_sel_off;
        miss_event = 1'b0;
        if (req_valid)
        begin
            case (src_t'(req_src))
                SRC_PROC:
                begin
                    if (req_line_inval && req_noncoh_space)
                        dest_nxt = DEST_DROP;
                    else if (req_special)
                        dest_nxt = DEST_OTHER;
                    else
                    begin
                        coh_nxt = 1'b1;
                        dest_nxt = local_hit ? DEST_LOCAL : DEST_SCALE;
                    end
                end
                SRC_HUB:
                begin
                    if (req_special)
                        dest_nxt = DEST_OTHER;
                    else
                    begin
                        dest_nxt = DEST_SCALE;
                        attr_nxt = ATTR_DRAM;
                    end
                end
                SRC_HOME:
                begin
                    coh_nxt = 1'b1;
                    if (local_hit)
                        dest_nxt = DEST_LOCAL;
                    else
                    begin
                        dest_nxt = DEST_ABORT;
                        miss_event = 1'b1;
                    end
                end
                SRC_SWITCH:
                begin
                    way_nxt = sw_sel_way;
                    off_nxt = sw_sel_off;
                    coh_nxt = req_coherent;
                    // coherent traffic never looks at the attribute
                    if (req_coherent || attr_in == ATTR_DRAM)
                    begin
                        coh_nxt = 1'b1;
                        if (sw_found || req_coherent)
                        begin
                            dest_nxt = DEST_PORT;
                            port_nxt = sw_sel_port;
                        end
                        else
                        begin
                            dest_nxt = DEST_COMPAT;
                            attr_nxt = ATTR_COMPAT;
                            coh_nxt = 1'b0;
                        end
                    end
                    else
                    begin
                        dest_nxt = DEST_OTHER;
                        attr_nxt = attr_in;
                    end
                end
                default:
                    dest_nxt = DEST_NONE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rsp_valid_r <= 1'b0;
            dest_r <= DEST_NONE;
            attr_r <= ATTR_UNDECODED;
            coh_r <= 1'b0;
            port_r <= '0;
            way_r <= 2'b00;
            off_r <= '0;
        end
        else
        begin
            rsp_valid_r <= rsp_valid_nxt;
            dest_r <= dest_nxt;
            attr_r <= attr_nxt;
            coh_r <= coh_nxt;
            port_r <= port_nxt;
            way_r <= way_nxt;
            off_r <= off_nxt;
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp_dest = dest_r;
    assign rsp_attr = attr_r;
    assign rsp_coherent = coh_r;
    assign rsp_port = port_r;
    assign rsp_way = way_r;
    assign rsp_offset = off_r;

    // ------------------------------------------------------------
    // apb register file
    // ------------------------------------------------------------
    logic err_flag_r, err_flag_nxt;
    logic [ADDR_W-1:0] err_addr_r, err_addr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic wr_en, mapped;
    logic [3:0] widx;

    assign wr_en = psel && penable && pwrite;
    assign widx = paddr[5:2];

    always_comb
    begin
        mapped = (paddr[1:0] == 2'b00)
            && ((paddr < OFS_SWITCH_RANGE + 12'h018)
                || (paddr >= OFS_SWITCH_PORTS && paddr < OFS_SWITCH_PORTS + 12'h018)
                || paddr == OFS_ERR_STATUS || paddr == OFS_ERR_ADDR_LO
                || paddr == OFS_ERR_ADDR_HI);
        node_cfg_nxt = node_cfg_r;
        sw_cfg_nxt = sw_cfg_r;
        sw_port_nxt = sw_port_r;
        if (wr_en && mapped)
        begin
            if (paddr < OFS_SWITCH_RANGE)
                node_cfg_nxt[widx[2:0]] = pwdata;
            else if (paddr < OFS_SWITCH_PORTS)
                sw_cfg_nxt[3'(widx - 4'h8)] = pwdata;
            else if (paddr < OFS_ERR_STATUS)
                sw_port_nxt[widx[2:0]] = pwdata[4*PORT_W-1:0];
        end
        err_flag_nxt = err_flag_r;
        err_addr_nxt = err_addr_r;
        if (wr_en && paddr == OFS_ERR_STATUS && pwdata[ERR_ILLEGAL_BIT])
            err_flag_nxt = 1'b0;
        // first error only; a new miss beats a clear in the same cycle
        if (miss_event)
        begin
            err_flag_nxt = 1'b1;
            if (!err_flag_r)
                err_addr_nxt = req_addr;
        end
        prdata_nxt = prdata_r;
        if (psel && !penable)
        begin
            prdata_nxt = 32'h0000_0000;
            if (paddr == OFS_ERR_STATUS)
                prdata_nxt = {31'h0, err_flag_r};
            else if (paddr == OFS_ERR_ADDR_LO)
                prdata_nxt = err_addr_r[31:0];
            else if (paddr == OFS_ERR_ADDR_HI)
                prdata_nxt = {20'h0, err_addr_r[ADDR_W-1:32]};
            else if (mapped && paddr < OFS_SWITCH_RANGE)
                prdata_nxt = node_cfg_r[widx[2:0]];
            else if (mapped && paddr < OFS_SWITCH_PORTS)
                prdata_nxt = sw_cfg_r[3'(widx - 4'h8)];
            else if (mapped)
                prdata_nxt = {20'h0, sw_port_r[widx[2:0]]};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NODE_RANGES; i++)
                node_cfg_r[i] <= RANGE_RST;
            for (int i = 0; i < SWITCH_RANGES; i++)
            begin
                sw_cfg_r[i] <= RANGE_RST;
                sw_port_r[i] <= '0;
            end
            err_flag_r <= 1'b0;
            err_addr_r <= '0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            node_cfg_r <= node_cfg_nxt;
            sw_cfg_r <= sw_cfg_nxt;
            sw_port_r <= sw_port_nxt;
            err_flag_r <= err_flag_nxt;
            err_addr_r <= err_addr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // zero wait states: read data were fetched in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;
    assign illegal_addr = err_flag_r;
endmodule : memory_interleave_router

// >>> dv/req_agent.sv
`timescale 1ns/1ps
module req_agent
    import router_pkg::*;
(
    input wire logic pclk,
    output logic req_valid,
    output logic [1:0] req_src,
    output logic [ADDR_W-1:0] req_addr,
    output logic req_coherent,
    output logic req_line_inval,
    output logic req_noncoh_space,
    output logic req_special,
    output logic [3:0] req_attr
);
    initial
    begin
        req_valid = 1'b0;
        req_src = 2'h0;
        req_addr = '0;
        {req_coherent, req_line_inval, req_noncoh_space, req_special} = 4'h0;
        req_attr = 4'h0;
    end

    // ----------------------------------------
    // one request, then stale fields inverted
    // ----------------------------------------
    // f packs coherent, invalidate, non-coherent space, special
    task automatic send(input logic [1:0] s, input logic [ADDR_W-1:0] a,
        input logic [3:0] f, input logic [3:0] t);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_src <= s;
        req_addr <= a;
        {req_coherent, req_line_inval, req_noncoh_space, req_special} <= f;
        req_attr <= t;
        @(posedge pclk);
        req_valid <= 1'b0;
        req_src <= ~s;
        req_addr <= ~a;
        {req_coherent, req_line_inval, req_noncoh_space, req_special} <= ~f;
        req_attr <= ~t;
    endtask : send
endmodule : req_agent

// >>> dv/memory_interleave_router_asserts.sv
`timescale 1ns/1ps
module router_checker
    import router_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req_valid,
    input wire logic [1:0] req_src,
    input wire logic req_line_inval,
    input wire logic req_noncoh_space,
    input wire logic req_special,
    input wire logic rsp_valid,
    input wire logic [2:0] rsp_dest,
    input wire logic [3:0] rsp_attr,
    input wire logic rsp_coherent,
    input wire logic [PORT_W-1:0] rsp_port,
    input wire logic illegal_addr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    resp_pulse_a: assert property (req_valid |=> rsp_valid)
        else $error("request without response");
    no_spurious_a: assert property (!req_valid |=> !rsp_valid)
        else $error("response without request");
    drop_inval_a: assert property (req_valid && req_src == SRC_PROC && req_line_inval
        && req_noncoh_space |=> rsp_dest == DEST_DROP)
        else $error("invalidate to non-coherent space not dropped");
    proc_route_a: assert property (req_valid && req_src == SRC_PROC && !req_special
        && !(req_line_inval && req_noncoh_space)
        |=> (rsp_dest == DEST_LOCAL || rsp_dest == DEST_SCALE) && rsp_coherent)
        else $error("processor memory request misrouted");
    hub_route_a: assert property (req_valid && req_src == SRC_HUB && !req_special
        |=> rsp_dest == DEST_SCALE && rsp_attr == ATTR_DRAM)
        else $error("hub request not sent to scalability port as dram");
    home_route_a: assert property (req_valid && req_src == SRC_HOME
        |=> rsp_dest == DEST_LOCAL || rsp_dest == DEST_ABORT)
        else $error("home request neither local nor aborted");
    abort_flag_a: assert property (rsp_valid && rsp_dest == DEST_ABORT |-> illegal_addr)
        else $error("abort without illegal flag");
    flag_cause_a: assert property ($rose(illegal_addr) |-> rsp_valid && rsp_dest == DEST_ABORT)
        else $error("illegal flag rose without abort");
    compat_attr_a: assert property (rsp_valid && rsp_dest == DEST_COMPAT
        |-> rsp_attr == ATTR_COMPAT)
        else $error("compatibility route without its attribute");
    port_idle_a: assert property (rsp_valid && rsp_dest != DEST_PORT |-> rsp_port == '0)
        else $error("port number outside switch routing");
endmodule : router_checker

bind memory_interleave_router router_checker router_checker_i (.pclk(pclk), .presetn(presetn),
    .req_valid(req_valid), .req_src(req_src), .req_line_inval(req_line_inval),
    .req_noncoh_space(req_noncoh_space), .req_special(req_special), .rsp_valid(rsp_valid),
    .rsp_dest(rsp_dest), .rsp_attr(rsp_attr), .rsp_coherent(rsp_coherent),
    .rsp_port(rsp_port), .illegal_addr(illegal_addr));

// >>> dv/memory_interleave_router_tb.sv
`timescale 1ns/1ps
module memory_interleave_router_tb
    import router_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_q;
    logic pready, pslverr, err_q;
    logic req_valid, req_coherent, req_line_inval, req_noncoh_space, req_special;
    logic [1:0] req_src, rsp_way;
    logic [ADDR_W-1:0] req_addr, rsp_offset;
    logic [3:0] req_attr, rsp_attr;
    logic rsp_valid, rsp_coherent, illegal_addr;
    logic [2:0] rsp_dest;
    logic [PORT_W-1:0] rsp_port;
    int num_errors = 0;
    int n_tests = 0;
    localparam logic [3:0] NOCHK = 4'hf;

    memory_interleave_router memory_interleave_router_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
        .req_src(req_src), .req_addr(req_addr), .req_coherent(req_coherent),
        .req_line_inval(req_line_inval), .req_noncoh_space(req_noncoh_space),
        .req_special(req_special), .req_attr(req_attr), .rsp_valid(rsp_valid),
        .rsp_dest(rsp_dest), .rsp_attr(rsp_attr), .rsp_coherent(rsp_coherent),
        .rsp_port(rsp_port), .rsp_way(rsp_way), .rsp_offset(rsp_offset),
        .illegal_addr(illegal_addr));

    req_agent req_agent_i (.pclk(pclk), .req_valid(req_valid), .req_src(req_src),
        .req_addr(req_addr), .req_coherent(req_coherent), .req_line_inval(req_line_inval),
        .req_noncoh_space(req_noncoh_space), .req_special(req_special), .req_attr(req_attr));

    initial
    begin
        forever #2.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask : cmp

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no assumed latency: only the watchdog ends a stuck wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic x);
        apb(a, 1'b0, 32'h0);
        cmp(rd_q, e, "read data");
        cmp(err_q, x, "slave error");
    endtask : rd

    // ea of NOCHK leaves the attribute unchecked
    task automatic rq(input logic [1:0] s, input logic [ADDR_W-1:0] a, input logic [3:0] f,
        input logic [3:0] t, input logic [2:0] dst, input logic [3:0] ea,
        input logic [PORT_W-1:0] ep);
        req_agent_i.send(s, a, f, t);
        #1;
        cmp(rsp_valid, 1'b1, "response pulse");
        cmp(rsp_dest, dst, "destination");
        cmp(rsp_port, ep, "port");
        if (ea !== NOCHK)
            cmp(rsp_attr, ea, "attribute");
    endtask : rq

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    initial
    begin
        #20000;
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        final_report();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(12'(4 * i), RANGE_RST, 1'b0);
        rd(OFS_ERR_STATUS, 32'h0, 1'b0);
        rd(12'h038, 32'h0, 1'b1);
        rd(12'h002, 32'h0, 1'b1);
        wr(12'h01c, 32'h0000_1234);
        rd(12'h01c, 32'h0000_1234, 1'b0);
        wr(12'h034, 32'h0000_5678);
        rd(12'h034, 32'h0000_5678, 1'b0);
        done("registers");
        // fine range owning way 0, block range owning way 2, its reflection, overlap
        wr(OFS_NODE_RANGE, 32'h0380_0000);
        wr(12'h004, 32'h0900_0001);
        wr(12'h008, 32'h0900_0002);
        wr(12'h00c, 32'h0100_0000);
        // 128 MB block range at 256 MB owning way 3
        wr(12'h010, 32'h1104_0004);
        rq(SRC_PROC, 44'h204, 4'h0, 4'h0, DEST_LOCAL, 4'h0, 3'h0);
        cmp(rsp_coherent, 1'b1, "coherent");
        cmp(rsp_way, 2'h0, "way");
        cmp(rsp_offset, 44'h204, "offset");
        rq(SRC_PROC, 44'h080, 4'h0, 4'h0, DEST_SCALE, 4'h0, 3'h0);
        rq(SRC_PROC, 44'h100, 4'h0, 4'h0, DEST_SCALE, 4'h0, 3'h0);
        rq(SRC_PROC, 44'h600_0000, 4'h0, 4'h0, DEST_LOCAL, 4'h0, 3'h0);
        cmp(rsp_way, 2'h2, "way");
        cmp(rsp_offset, 44'h200_0000, "offset");
        rq(SRC_PROC, 44'ha00_0000, 4'h0, 4'h0, DEST_LOCAL, 4'h0, 3'h0);
        cmp(rsp_offset, 44'h200_0000, "offset");
        rq(SRC_PROC, 44'h500_0000, 4'h0, 4'h0, DEST_SCALE, 4'h0, 3'h0);
        rq(SRC_PROC, 44'h1600_0000, 4'h0, 4'h0, DEST_LOCAL, 4'h0, 3'h0);
        cmp(rsp_way, 2'h3, "way");
        cmp(rsp_offset, 44'h600_0000, "offset");
        rq(SRC_PROC, 44'h1400_0000, 4'h0, 4'h0, DEST_SCALE, 4'h0, 3'h0);
        cmp(rsp_way, 2'h2, "way");
        rq(SRC_PROC, 44'h0, 4'h6, 4'h0, DEST_DROP, NOCHK, 3'h0);
        rq(SRC_PROC, 44'h204, 4'h1, 4'h0, DEST_OTHER, NOCHK, 3'h0);
        done("node routing");
        rq(SRC_HUB, 44'h204, 4'h0, 4'h0, DEST_SCALE, ATTR_DRAM, 3'h0);
        rq(SRC_HUB, 44'h204, 4'h1, 4'h0, DEST_OTHER, NOCHK, 3'h0);
        done("hub routing");
        rq(SRC_HOME, 44'h204, 4'h0, 4'h0, DEST_LOCAL, NOCHK, 3'h0);
        cmp(illegal_addr, 1'b0, "flag idle");
        rq(SRC_HOME, 44'h123_4567_8900, 4'h0, 4'h0, DEST_ABORT, NOCHK, 3'h0);
        cmp(illegal_addr, 1'b1, "flag set");
        rq(SRC_HOME, 44'h100, 4'h0, 4'h0, DEST_ABORT, NOCHK, 3'h0);
        rd(OFS_ERR_STATUS, 32'h1, 1'b0);
        rd(OFS_ERR_ADDR_LO, 32'h4567_8900, 1'b0);
        rd(OFS_ERR_ADDR_HI, 32'h0000_0123, 1'b0);
        wr(OFS_ERR_STATUS, 32'h1);
        rd(OFS_ERR_STATUS, 32'h0, 1'b0);
        cmp(illegal_addr, 1'b0, "flag cleared");
        done("home node");
        // way ports 1, 2, 3, 4
        wr(OFS_SWITCH_RANGE, 32'h0180_0000);
        wr(OFS_SWITCH_PORTS, 32'h0000_08d1);
        rq(SRC_SWITCH, 44'h080, 4'h0, ATTR_DRAM, DEST_PORT, NOCHK, 3'h2);
        cmp(rsp_coherent, 1'b1, "coherent");
        cmp(rsp_way, 2'h1, "way");
        rq(SRC_SWITCH, 44'h180, 4'h8, 4'h9, DEST_PORT, NOCHK, 3'h4);
        rq(SRC_SWITCH, 44'h123_0000_0000, 4'h8, 4'h0, DEST_PORT, NOCHK, 3'h1);
        rq(SRC_SWITCH, 44'h123_0000_0000, 4'h0, ATTR_DRAM, DEST_COMPAT, ATTR_COMPAT, 3'h0);
        cmp(rsp_coherent, 1'b0, "coherent");
        rq(SRC_SWITCH, 44'h080, 4'h0, 4'h9, DEST_OTHER, ATTR_UNDECODED, 3'h0);
        done("switch routing");
        // second reset in mid-run: every range must come back disabled
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_NODE_RANGE, RANGE_RST, 1'b0);
        rd(OFS_SWITCH_PORTS, 32'h0, 1'b0);
        rq(SRC_PROC, 44'h204, 4'h0, 4'h0, DEST_SCALE, 4'h0, 3'h0);
        done("reset");
        final_report();
    end
endmodule : memory_interleave_router_tb
